// [rtl/psw_regs.vh]
`ifndef PSW_REGS_VH
`define PSW_REGS_VH
`define PSW_MODE_USER 4'h1
`define PSW_STATUS_USER 4'h8
`define PSW_FEN_MEM_OFS 64'h0000_0000_0000_0028
`define PSW_FEN_MASK 64'h0000_0000_0000_0001
`define PSW_OP_WHOAMI 4'h0
`define PSW_OP_WRENT 4'h1
`define PSW_OP_WRFEN 4'h2
`define PSW_OP_WRKGP 4'h3
`define PSW_OP_WRUSP 4'h4
`define PSW_OP_RDUSP 4'h5
`define PSW_OP_WRVAL 4'h6
`define PSW_OP_RDVAL 4'h7
`define PSW_OP_WRVPT 4'h8
`define PSW_SEL_INT 64'h0000_0000_0000_0000
`define PSW_SEL_ARITH 64'h0000_0000_0000_0001
`define PSW_SEL_MM 64'h0000_0000_0000_0002
`define PSW_SEL_IF 64'h0000_0000_0000_0003
`define PSW_SEL_UNA 64'h0000_0000_0000_0004
`define PSW_SEL_SYS 64'h0000_0000_0000_0005
`define PSW_ZERO64 64'h0000_0000_0000_0000
`define PSW_FEN_BIT 0
`define PSW_NUM_ENTRIES 6
`define PSW_IDX_INT 0
`define PSW_IDX_ARITH 1
`define PSW_IDX_MM 2
`define PSW_IDX_IF 3
`define PSW_IDX_UNA 4
`define PSW_IDX_SYS 5
`endif

// [rtl/psw_unit.v]
`timescale 1ns/1ps
`include "psw_regs.vh"
module psw_unit #(
  parameter PROC_NUM = 0,
  parameter PROC_LIMIT = 4
) (
  input wire mclk,
  input wire srst,
  input wire call_valid,
  input wire [3:0] call_op,
  input wire [3:0] status_mode,
  input wire [63:0] first_argument,
  input wire [63:0] second_argument,
  input wire [63:0] process_block_base,
  input wire exception_taken,
  output reg done_reg,
  output reg reserved_opcode_fault_reg,
  output reg [63:0] result_register_reg,
  output reg mem_wr_reg,
  output reg [63:0] mem_addr_reg,
  output reg [63:0] mem_data_reg,
  output reg gp_load_reg,
  output reg [63:0] global_pointer_reg,
  output reg [63:0] interrupt_entry_reg,
  output reg [63:0] arithmetic_trap_entry_reg,
  output reg [63:0] memory_fault_entry_reg,
  output reg [63:0] instruction_fault_entry_reg,
  output reg [63:0] unaligned_access_entry_reg,
  output reg [63:0] system_call_entry_reg,
  output reg float_unit_enable_reg,
  output reg [63:0] kernel_global_pointer_reg,
  output reg [63:0] saved_user_stack_reg,
  output reg [63:0] system_value_reg,
  output reg [63:0] virtual_table_base_reg
);
  // Processor number is a configuration constant; no call path writes it.
  localparam [63:0] WHOAMI = PROC_NUM % PROC_LIMIT;
  localparam NUM_ENTRIES = `PSW_NUM_ENTRIES;

  wire user_mode;
  wire call_ok;
  wire op_known;
  wire [NUM_ENTRIES-1:0] entry_we;

  reg done_next;
  reg fault_next;
  reg [63:0] result_next;
  reg mem_wr_next;
  reg [63:0] mem_addr_next;
  reg [63:0] mem_data_next;
  reg gp_load_next;
  reg [63:0] global_pointer_next;
  reg float_unit_enable_next;
  reg [63:0] kernel_global_pointer_next;
  reg [63:0] saved_user_stack_next;
  reg [63:0] system_value_next;
  reg [63:0] virtual_table_base_next;

  assign user_mode = (status_mode == `PSW_MODE_USER);
  // Every call-driven state write is gated here, so a refused user call can never leak into state.
  assign call_ok = call_valid && !user_mode;
  assign op_known = (call_op <= `PSW_OP_WRVPT);

  genvar i;
  generate
    for (i = 0; i < NUM_ENTRIES; i = i + 1) begin : g_entry_sel
      localparam [63:0] SEL = i;
      // Selectors past the last entry match no slot, so such a call changes nothing.
      assign entry_we[i] = call_ok && (call_op == `PSW_OP_WRENT) && (second_argument == SEL);
    end
  endgenerate

  // The argument registers belong to the core; this block only reads them.
  always @* begin
    done_next = call_valid && op_known;
    fault_next = call_valid && (user_mode || !op_known);
    result_next = result_register_reg;
    mem_wr_next = 1'b0;
    mem_addr_next = mem_addr_reg;
    mem_data_next = mem_data_reg;
    gp_load_next = exception_taken;
    global_pointer_next = global_pointer_reg;
    float_unit_enable_next = float_unit_enable_reg;
    kernel_global_pointer_next = kernel_global_pointer_reg;
    saved_user_stack_next = saved_user_stack_reg;
    system_value_next = system_value_reg;
    virtual_table_base_next = virtual_table_base_reg;
    // The reload takes the pointer held before any write in the same cycle.
    if (exception_taken) begin
      global_pointer_next = kernel_global_pointer_reg;
    end
    if (call_ok) begin
      case (call_op)
        `PSW_OP_WHOAMI: begin
          result_next = WHOAMI;
        end
        `PSW_OP_WRENT: begin
          // Entry writes are decoded per slot in the generate loop above.
        end
        `PSW_OP_WRFEN: begin
          float_unit_enable_next = first_argument[`PSW_FEN_BIT];
          mem_wr_next = 1'b1;
          mem_addr_next = process_block_base + `PSW_FEN_MEM_OFS;
          mem_data_next = first_argument & `PSW_FEN_MASK;
        end
        `PSW_OP_WRKGP: begin
          kernel_global_pointer_next = first_argument;
        end
        `PSW_OP_WRUSP: begin
          saved_user_stack_next = first_argument;
        end
        `PSW_OP_RDUSP: begin
          result_next = saved_user_stack_reg;
        end
        `PSW_OP_WRVAL: begin
          system_value_next = first_argument;
        end
        `PSW_OP_RDVAL: begin
          result_next = system_value_reg;
        end
        `PSW_OP_WRVPT: begin
          virtual_table_base_next = first_argument;
        end
        default: begin
        end
      endcase
    end
  end

  // Completion and fault pulses are registered, one cycle behind each cycle that call_valid is high.
  always @(posedge mclk) begin
    if (srst) begin
      done_reg <= 1'b0;
      reserved_opcode_fault_reg <= 1'b0;
      mem_wr_reg <= 1'b0;
      gp_load_reg <= 1'b0;
    end else begin
      done_reg <= done_next;
      reserved_opcode_fault_reg <= fault_next;
      mem_wr_reg <= mem_wr_next;
      gp_load_reg <= gp_load_next;
    end
  end

  // Result and memory words hold until the next call that writes them.
  always @(posedge mclk) begin
    if (srst) begin
      result_register_reg <= `PSW_ZERO64;
      mem_addr_reg <= `PSW_ZERO64;
      mem_data_reg <= `PSW_ZERO64;
      global_pointer_reg <= `PSW_ZERO64;
    end else begin
      result_register_reg <= result_next;
      mem_addr_reg <= mem_addr_next;
      mem_data_reg <= mem_data_next;
      global_pointer_reg <= global_pointer_next;
    end
  end

  always @(posedge mclk) begin
    if (srst) begin
      float_unit_enable_reg <= 1'b0;
    end else begin
      float_unit_enable_reg <= float_unit_enable_next;
    end
  end

  always @(posedge mclk) begin
    if (srst) begin
      kernel_global_pointer_reg <= `PSW_ZERO64;
    end else begin
      kernel_global_pointer_reg <= kernel_global_pointer_next;
    end
  end

  always @(posedge mclk) begin
    if (srst) begin
      saved_user_stack_reg <= `PSW_ZERO64;
    end else begin
      saved_user_stack_reg <= saved_user_stack_next;
    end
  end

  always @(posedge mclk) begin
    if (srst) begin
      system_value_reg <= `PSW_ZERO64;
    end else begin
      system_value_reg <= system_value_next;
    end
  end

  always @(posedge mclk) begin
    if (srst) begin
      virtual_table_base_reg <= `PSW_ZERO64;
    end else begin
      virtual_table_base_reg <= virtual_table_base_next;
    end
  end

  // Entries keep their value unless their own slot is selected.
  always @(posedge mclk) begin
    if (srst) begin
      interrupt_entry_reg <= `PSW_ZERO64;
      arithmetic_trap_entry_reg <= `PSW_ZERO64;
      memory_fault_entry_reg <= `PSW_ZERO64;
      instruction_fault_entry_reg <= `PSW_ZERO64;
      unaligned_access_entry_reg <= `PSW_ZERO64;
      system_call_entry_reg <= `PSW_ZERO64;
    end else begin
      if (entry_we[`PSW_IDX_INT]) begin
        interrupt_entry_reg <= first_argument;
      end
      if (entry_we[`PSW_IDX_ARITH]) begin
        arithmetic_trap_entry_reg <= first_argument;
      end
      if (entry_we[`PSW_IDX_MM]) begin
        memory_fault_entry_reg <= first_argument;
      end
      if (entry_we[`PSW_IDX_IF]) begin
        instruction_fault_entry_reg <= first_argument;
      end
      if (entry_we[`PSW_IDX_UNA]) begin
        unaligned_access_entry_reg <= first_argument;
      end
      if (entry_we[`PSW_IDX_SYS]) begin
        system_call_entry_reg <= first_argument;
      end
    end
  end
endmodule

// [tb/psw_core_model.sv]
`timescale 1ns/1ps
module psw_core_model (
  input wire mclk,
  output reg call_valid,
  output reg [3:0] call_op,
  output reg [3:0] status_mode,
  output reg [63:0] first_argument,
  output reg [63:0] second_argument
);
  initial {call_valid, call_op, status_mode, first_argument, second_argument} = 137'h0;
  task issue(input [3:0] o, input [3:0] m, input [63:0] a, input [63:0] b);
    @(negedge mclk);
    {call_valid, call_op, status_mode, first_argument, second_argument} = {1'h1, o, m, a, b};
    @(negedge mclk);
    // Arguments are scrambled after each call so nothing can lean on them.
    {call_valid, first_argument, second_argument} = {1'h0, ~a, ~b};
  endtask
endmodule

// [tb/psw_unit_properties.sv]
`timescale 1ns/1ps
module psw_unit_properties (
  input wire mclk,
  input wire srst,
  input wire call_valid,
  input wire [3:0] call_op,
  input wire [3:0] status_mode,
  input wire [63:0] first_argument,
  input wire done_reg,
  input wire reserved_opcode_fault_reg,
  input wire [63:0] kernel_global_pointer_reg,
  input wire exception_taken,
  input wire gp_load_reg,
  input wire [63:0] global_pointer_reg
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  wire kv = call_valid && status_mode != 4'h1;
  sequence s_user; call_valid && status_mode == 4'h1 && call_op < 4'h9; endsequence
  a_user_fault: assert property (s_user |=> reserved_opcode_fault_reg && done_reg) else $error("fault");
  a_user_keep: assert property (s_user |=> $stable(kernel_global_pointer_reg)) else $error("kept");
  a_kgp_load: assert property (kv && call_op == 4'h3 |=> kernel_global_pointer_reg == $past(first_argument))
    else $error("kgp");
  a_kgp_hold: assert property (!(kv && call_op == 4'h3) |=> $stable(kernel_global_pointer_reg)) else $error("hold");
  a_kernel_done: assert property (kv && call_op < 4'h9 |=> done_reg && !reserved_opcode_fault_reg)
    else $error("done");
  a_idle_quiet: assert property (!call_valid |=> !done_reg && !reserved_opcode_fault_reg) else $error("idle");
  a_done_cause: assert property (done_reg |-> $past(call_valid) && $past(call_op) < 4'h9) else $error("cause");
  a_fault_why: assert property (reserved_opcode_fault_reg |->
    $past(status_mode) == 4'h1 || $past(call_op) > 4'h8) else $error("why");
  sequence s_exc; exception_taken; endsequence
  a_gp_reload: assert property (s_exc |=> gp_load_reg && global_pointer_reg == $past(kernel_global_pointer_reg))
    else $error("gp");
endmodule
bind psw_unit psw_unit_properties psw_unit_properties_inst (.mclk(mclk), .srst(srst), .call_valid(call_valid),
  .call_op(call_op), .status_mode(status_mode), .first_argument(first_argument), .done_reg(done_reg),
  .reserved_opcode_fault_reg(reserved_opcode_fault_reg), .kernel_global_pointer_reg(kernel_global_pointer_reg),
  .exception_taken(exception_taken), .gp_load_reg(gp_load_reg), .global_pointer_reg(global_pointer_reg));

// [tb/test_psw_unit.sv]
`timescale 1ns/1ps
`define CHK(n,e,g) begin compares++; if ((g)!==(e)) begin num_errors++; \
  $display("ERROR %s exp %h got %h",n,e,g); end end
module test_psw_unit;
  reg mclk = 1'h0, srst = 1'h1;
  int num_errors = 0, compares = 0, cyc = 0;
  wire call_valid, done_reg, reserved_opcode_fault_reg, mem_wr_reg, gp_load_reg, float_unit_enable_reg;
  reg exception_taken = 1'h0;
  wire [3:0] call_op, status_mode;
  wire [63:0] first_argument, second_argument, result_register_reg, mem_addr_reg, mem_data_reg, e [6];
  wire [63:0] global_pointer_reg, kernel_global_pointer_reg, saved_user_stack_reg, system_value_reg;
  wire [63:0] virtual_table_base_reg, process_block_base = 64'h0000_0000_0000_1000;
  psw_unit #(.PROC_NUM(2)) psw_unit_inst (.*, .interrupt_entry_reg(e[0]), .arithmetic_trap_entry_reg(e[1]),
    .memory_fault_entry_reg(e[2]), .instruction_fault_entry_reg(e[3]), .unaligned_access_entry_reg(e[4]),
    .system_call_entry_reg(e[5]));
  psw_core_model core (.*);
  initial forever #20 mclk = ~mclk;
  always @(posedge mclk) if (++cyc > 300) begin num_errors++; tally_and_finish; end
  task t_entries;
    for (int s = 0; s < 7; s++) core.issue(4'h1, 4'h0, 64'hffff_fc00_0000_0100 + s, s);
    for (int s = 0; s < 6; s++) `CHK("entry", 64'hffff_fc00_0000_0100 + s, e[s])
  endtask
  task t_fen_user;
    core.issue(4'h3, 4'h0, 64'h0000_0000_0000_0077, 64'h0);
    core.issue(4'h3, 4'h1, 64'h0000_0000_0000_0055, 64'h0);
    `CHK("kgp", 64'h0000_0000_0000_0077, kernel_global_pointer_reg)
    core.issue(4'h2, 4'h0, 64'hffff_ffff_ffff_fffe, 64'h0);
    `CHK("fen", 2'h1, {float_unit_enable_reg, mem_wr_reg})
    core.issue(4'h2, 4'h0, 64'h0000_0000_0000_0003, 64'h0);
    `CHK("fen on", 1'h1, float_unit_enable_reg)
    `CHK("pcb", 128'h0000_0000_0000_1028_0000_0000_0000_0001, {mem_addr_reg, mem_data_reg})
  endtask
  task t_misc;
    core.issue(4'h4, 4'h0, 64'h0000_0000_7ff0_0000, 64'h0);
    core.issue(4'h5, 4'h0, 64'h0, 64'h0);
    `CHK("usp", 64'h0000_0000_7ff0_0000, result_register_reg)
    core.issue(4'h8, 4'h0, 64'hffff_fe00_0000_0000, 64'h0);
    `CHK("vpt", 64'hffff_fe00_0000_0000, virtual_table_base_reg)
    core.issue(4'h4, 4'h1, 64'h0, 64'h0);
    `CHK("user", {2'h3, 64'h0000_0000_7ff0_0000}, {done_reg, reserved_opcode_fault_reg, saved_user_stack_reg})
    core.issue(4'h9, 4'h0, 64'h0, 64'h0);
    `CHK("bad op", 2'h1, {done_reg, reserved_opcode_fault_reg})
    @(negedge mclk) exception_taken = 1'h1;
    @(negedge mclk) exception_taken = 1'h0;
    `CHK("gp", {1'h1, 64'h0000_0000_0000_0077}, {gp_load_reg, global_pointer_reg})
  endtask
  task t_reads;
    core.issue(4'h6, 4'h0, 64'hfedc_ba98_7654_3210, 64'h0);
    core.issue(4'h7, 4'h0, 64'h0, 64'h0);
    `CHK("val", 64'hfedc_ba98_7654_3210, result_register_reg)
    core.issue(4'h0, 4'h0, 64'h0, 64'h0);
    `CHK("who", 64'h0000_0000_0000_0002, result_register_reg)
  endtask
  initial begin
    repeat (16) @(negedge mclk);
    srst = 1'h0;
    t_entries;
    t_fen_user;
    t_reads;
    t_misc;
    tally_and_finish;
  end
  task tally_and_finish;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
endmodule
